// ==== hdl/timer_two_pkg.sv ====
// Constants, codes and helpers for the timer-two clock-out block.
// Assumes an 8-bit special function register port and one system clock.
package timer_two_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_MODE_EXT = 8'h93;
  localparam logic [7:0] ADDR_CTRL = 8'hc8;
  localparam logic [7:0] ADDR_MODE = 8'hc9;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // Control register bit positions
  localparam int CTRL_OVF = 7;
  localparam int CTRL_EXT = 6;
  localparam int CTRL_ALIAS_HI = 5;
  localparam int CTRL_ALIAS_LO = 4;
  localparam int CTRL_FALL_EN = 3;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_CT = 1;
  localparam int CTRL_CPRL = 0;

  // Mode register bit positions
  localparam int MODE_SPLIT = 7;
  localparam int MODE_LOW_X12 = 6;
  localparam int MODE_RISE_EN = 5;
  localparam int MODE_X12 = 4;
  localparam int MODE_LOW_RUN = 3;
  localparam int MODE_LOW_AUTOCLR = 2;
  localparam int MODE_OUT_EN = 1;
  localparam int MODE_MS0 = 0;

  // Mode extension register bit positions
  localparam int EXT_LOW_CS = 7;
  localparam int EXT_IGNORE = 6;
  localparam int EXT_BANK = 5;
  localparam int EXT_CKS = 4;
  localparam int EXT_MS1 = 3;
  localparam int EXT_CPS_HI = 2;

  // System clock divided by twelve
  localparam logic [3:0] PRESCALE_LAST = 4'hb;

  typedef enum logic [2:0] {
    MODE_AR_INT = 3'h0,
    MODE_AR_TRIG = 3'h1,
    MODE_CAPTURE = 3'h2,
    MODE_CAPTURE_ZERO = 3'h3,
    MODE_PWM = 3'h4
  } mode_t;

  // Count clock codes {source, x12, counter}
  localparam logic [2:0] CKS_DIV12 = 3'h0;
  localparam logic [2:0] CKS_SYSTEM_CLOCK = 3'h2;
  localparam logic [2:0] CKS_EVENT0 = 3'h3;
  localparam logic [2:0] CKS_BAUD = 3'h4;

  // Low counter select mapped onto the shared count clock codes
  function automatic logic [2:0] low_clock_code(input logic cs, input logic x12);
    unique case ({cs, x12})
      2'b00: low_clock_code = CKS_DIV12;
      2'b01: low_clock_code = CKS_SYSTEM_CLOCK;
      2'b10: low_clock_code = CKS_BAUD;
      default: low_clock_code = CKS_EVENT0;
    endcase
  endfunction

endpackage

// ==== hdl/timer_pin_sync.sv ====
// Two-flop synchroniser for the five asynchronous pins of the timer.
// Assumes the pins are unrelated to sys_clk.
`timescale 1ns/1ps
module timer_pin_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Pins in, synchronised levels out
  input wire logic [4:0] pin_async,
  output logic [4:0] pin_sync
);
  logic [4:0] meta_q;
  logic [4:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_q <= 5'h00;
      sync_q <= 5'h00;
    end else begin
      meta_q <= pin_async;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;
endmodule // timer_pin_sync

// ==== hdl/timer_tick_select.sv ====
// Eight-way count clock selector shared by the high and low counters.
// Assumes every source is a one-cycle enable on sys_clk.
`timescale 1ns/1ps
module timer_tick_select (
  // Select code
  input wire logic [2:0] sel,
  // Sources in code order
  input wire logic div12_tick,
  input wire logic pin_tick,
  input wire logic event0_tick,
  input wire logic baud_tick,
  input wire logic timer0_tick,
  input wire logic keypad_tick,
  // Chosen tick
  output logic tick
);
  // Code 110 is reserved and never ticks
  always_comb begin
    unique case (sel)
      3'h0: tick = div12_tick;
      3'h1: tick = pin_tick;
      3'h2: tick = 1'b1;
      3'h3: tick = event0_tick;
      3'h4: tick = baud_tick;
      3'h5: tick = timer0_tick;
      3'h6: tick = 1'b0;
      default: tick = keypad_tick;
    endcase
  end
endmodule // timer_tick_select

// ==== hdl/timer_two_clock_out_control.sv ====
// Timer two: 16-bit or split 8-bit counters, clock-out, flags and control registers.
// Assumes the CPU register port is on sys_clk and event inputs are one-cycle pulses on it.
`timescale 1ns/1ps
// Operation
// - Clock-out mode toggles output, 50% duty
// - Count up, reload both bytes on overflow
// - Output rate is clock over 2(65536-reload)
// - Overflow sets flag; ignore bit blocks interrupt
// - Split clock-out from low overflow, 256 reload
// - Low overflow flag, interrupt when enabled
// - One overflow stream feeds baud and output
// - No overflow flag while serial selects set
// - Flags cleared only by software
// - Enabled edges set external flag with action
// - Serial use: edges flag only, no action (code still auto-clears low run on capture-mode edges)
// - Select bits route overflow to serial clocks
// - Bank bit aliases control bits five, four
// - Run bits; split uses separate low run
// - Three-bit count clock source select
// - Two-bit low counter clock select
// - Auto-clear of low run bit
// - Mode code selects reload or capture
// - Split bit makes two 8-bit counters
// - Three-bit capture source select
// - Output driven only when enabled
module timer_two_clock_out_control (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Asynchronous pins
  input wire logic count_pin,
  input wire logic external_trigger_input,
  input wire logic serial_receive_input,
  input wire logic port6_bit0,
  input wire logic two_wire_clock_line,
  // On-chip event pulses
  input wire logic external_interrupt0_event,
  input wire logic external_interrupt2_event,
  input wire logic baud_generator_overflow,
  input wire logic timer_zero_overflow,
  input wire logic timer_one_overflow,
  input wire logic keypad_event,
  // Clock output pin
  output logic clock_out,
  output logic clock_out_oe,
  // Serial clocks, overflow and interrupt
  output logic rx_baud_clock,
  output logic tx_baud_clock,
  output logic overflow_event,
  output logic timer_irq
);
  logic [3:0] div_q;
  logic [3:0] div_d;
  logic [4:0] pin_s;
  logic count_prev_q;
  logic cap_prev_q;
  logic [7:0] mode_q;
  logic [7:0] ext_q;
  logic [7:0] tl_q, tl_d, th_q, th_d;
  logic [7:0] rcap_l_q, rcap_l_d, rcap_h_q, rcap_h_d;
  logic overflow_flag_q, overflow_flag_d;
  logic external_flag_q, external_flag_d;
  logic low_overflow_flag_q, low_overflow_flag_d;
  logic low_overflow_interrupt_enable_q;
  logic receive_clock_select_q, transmit_clock_select_q;
  logic falling_edge_enable_q, main_run_q, counter_timer_bit_q, capture_reload_select_q;
  logic low_run_d;
  logic clock_out_q, clock_out_oe_q, rx_q, tx_q, ovf_evt_q, irq_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Decoded fields
  wire split_mode = mode_q[timer_two_pkg::MODE_SPLIT];
  wire low_run = mode_q[timer_two_pkg::MODE_LOW_RUN];
  wire low_run_auto_clear = mode_q[timer_two_pkg::MODE_LOW_AUTOCLR];
  wire clock_output_enable = mode_q[timer_two_pkg::MODE_OUT_EN];
  wire rising_edge_enable = mode_q[timer_two_pkg::MODE_RISE_EN];
  wire overflow_interrupt_ignore = ext_q[timer_two_pkg::EXT_IGNORE];
  wire bit_bank_select = ext_q[timer_two_pkg::EXT_BANK];
  wire [2:0] capture_source_select = ext_q[timer_two_pkg::EXT_CPS_HI:0];
  wire [2:0] hi_clock_code = {ext_q[timer_two_pkg::EXT_CKS], mode_q[timer_two_pkg::MODE_X12], counter_timer_bit_q};
  wire [2:0] lo_clock_code = timer_two_pkg::low_clock_code(ext_q[timer_two_pkg::EXT_LOW_CS],
                                                           mode_q[timer_two_pkg::MODE_LOW_X12]);
  wire [2:0] mode_code = {ext_q[timer_two_pkg::EXT_MS1], capture_reload_select_q, mode_q[timer_two_pkg::MODE_MS0]};
  wire serial_use = receive_clock_select_q | transmit_clock_select_q;

  // Register port strobes
  wire wr_ctrl = sfr_wr && (sfr_addr == timer_two_pkg::ADDR_CTRL);
  wire wr_mode = sfr_wr && (sfr_addr == timer_two_pkg::ADDR_MODE);
  wire wr_ext = sfr_wr && (sfr_addr == timer_two_pkg::ADDR_MODE_EXT);
  wire wr_tl = sfr_wr && (sfr_addr == timer_two_pkg::ADDR_COUNT_LOW);
  wire wr_th = sfr_wr && (sfr_addr == timer_two_pkg::ADDR_COUNT_HIGH);
  wire wr_rl = sfr_wr && (sfr_addr == timer_two_pkg::ADDR_RELOAD_LOW);
  wire wr_rh = sfr_wr && (sfr_addr == timer_two_pkg::ADDR_RELOAD_HIGH);

  // Divide-by-twelve enable
  wire div12_tick = (div_q == timer_two_pkg::PRESCALE_LAST);
  assign div_d = div12_tick ? 4'h0 : div_q + 4'h1;

  timer_pin_sync u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_async({two_wire_clock_line, port6_bit0, serial_receive_input, external_trigger_input, count_pin}),
    .pin_sync(pin_s)
  );

  // Counter pin counts on its falling edge
  wire pin_tick = count_prev_q & ~pin_s[0];

  // Low counter clock and overflow
  wire lo_tick;
  timer_tick_select u_lo_sel (
    .sel(lo_clock_code),
    .div12_tick(div12_tick),
    .pin_tick(1'b0),
    .event0_tick(external_interrupt0_event),
    .baud_tick(baud_generator_overflow),
    .timer0_tick(1'b0),
    .keypad_tick(1'b0),
    .tick(lo_tick)
  );
  wire lo_step = split_mode & low_run & lo_tick;
  wire low_byte_overflow_event = lo_step & (tl_q == 8'hff);

  // High or full counter clock; split code 011 takes the low overflow
  wire hi_tick;
  timer_tick_select u_hi_sel (
    .sel(hi_clock_code),
    .div12_tick(div12_tick),
    .pin_tick(pin_tick),
    .event0_tick(split_mode ? low_byte_overflow_event : external_interrupt0_event),
    .baud_tick(baud_generator_overflow),
    .timer0_tick(timer_zero_overflow),
    .keypad_tick(keypad_event),
    .tick(hi_tick)
  );
  wire hi_step = main_run_q & hi_tick;
  wire full_step = ~split_mode & hi_step;
  wire full_ovf = full_step & ({th_q, tl_q} == 16'hffff);
  wire split_hi_ovf = split_mode & hi_step & (th_q == 8'hff);
  wire hi_ovf = full_ovf | split_hi_ovf;
  // Split mode replaces the full overflow by the low overflow
  wire t2_ovf = split_mode ? low_byte_overflow_event : full_ovf;
  // Serial use and clock-out both reload on overflow
  wire reload_on_ovf = ~capture_reload_select_q | serial_use;

  // Capture source and edge detection
  wire cap_level;
  assign cap_level = (capture_source_select == 3'h0) ? pin_s[1] :
                     (capture_source_select == 3'h1) ? pin_s[2] :
                     (capture_source_select == 3'h2) ? pin_s[3] :
                     (capture_source_select == 3'h3) ? external_interrupt2_event :
                     (capture_source_select == 3'h6) ? keypad_event :
                     (capture_source_select == 3'h7) ? pin_s[4] : 1'b0;
  wire cap_fall = cap_prev_q & ~cap_level;
  wire cap_rise = ~cap_prev_q & cap_level;
  wire ext_evt = (cap_fall & falling_edge_enable_q) | (cap_rise & rising_edge_enable);
  // Serial use blocks reload and capture, not the flag or the low run auto-clear
  wire ext_act = ext_evt & ~serial_use;
  wire trig_reload = ext_act & (mode_code == timer_two_pkg::MODE_AR_TRIG);
  wire capture_take = ext_act & ((mode_code == timer_two_pkg::MODE_CAPTURE) |
                                 (mode_code == timer_two_pkg::MODE_CAPTURE_ZERO));
  wire zero_take = ext_act & (mode_code == timer_two_pkg::MODE_CAPTURE_ZERO);
  wire mode_01 = (mode_code == timer_two_pkg::MODE_AR_INT) | (mode_code == timer_two_pkg::MODE_AR_TRIG);
  wire mode_23 = (mode_code == timer_two_pkg::MODE_CAPTURE) | (mode_code == timer_two_pkg::MODE_CAPTURE_ZERO);
  wire low_run_clear = low_run_auto_clear & ((mode_01 & hi_ovf) | (mode_23 & ext_evt));

  // Count bytes; a write from the CPU beats counting
  always_comb begin
    tl_d = tl_q;
    th_d = th_q;
    if (!split_mode) begin
      if (zero_take) begin
        {th_d, tl_d} = timer_two_pkg::RESET_WORD;
      end else if (trig_reload || (full_ovf && reload_on_ovf)) begin
        {th_d, tl_d} = {rcap_h_q, rcap_l_q};
      end else if (full_step) begin
        {th_d, tl_d} = {th_q, tl_q} + 16'h0001;
      end
    end else begin
      if (lo_step) begin
        tl_d = (tl_q == 8'hff) ? rcap_l_q : tl_q + 8'h01;
      end
      if (zero_take) begin
        th_d = timer_two_pkg::RESET_BYTE;
      end else if (trig_reload || (split_hi_ovf && reload_on_ovf)) begin
        th_d = rcap_h_q;
      end else if (hi_step) begin
        th_d = th_q + 8'h01;
      end
    end
    if (wr_tl) begin
      tl_d = sfr_wdata;
    end
    if (wr_th) begin
      th_d = sfr_wdata;
    end
  end

  // Reload bytes; capture takes the live count
  assign rcap_l_d = wr_rl ? sfr_wdata : (capture_take && !split_mode) ? tl_q : rcap_l_q;
  assign rcap_h_d = wr_rh ? sfr_wdata : capture_take ? th_q : rcap_h_q;

  // Flags: a hardware set wins over a software clear in the same cycle
  assign overflow_flag_d = (wr_ctrl ? sfr_wdata[timer_two_pkg::CTRL_OVF] : overflow_flag_q)
                           | (hi_ovf & ~serial_use);
  assign external_flag_d = (wr_ctrl ? sfr_wdata[timer_two_pkg::CTRL_EXT] : external_flag_q)
                           | ext_evt;
  assign low_overflow_flag_d = ((wr_ctrl && bit_bank_select) ? sfr_wdata[timer_two_pkg::CTRL_ALIAS_HI]
                                : low_overflow_flag_q) | low_byte_overflow_event;
  // Hardware clear of the low run bit beats a write setting it
  assign low_run_d = (wr_mode ? sfr_wdata[timer_two_pkg::MODE_LOW_RUN] : low_run) & ~low_run_clear;

  // Read data, unmapped addresses read zero
  wire [7:0] ctrl_read = {overflow_flag_q, external_flag_q,
                          bit_bank_select ? low_overflow_flag_q : receive_clock_select_q,
                          bit_bank_select ? low_overflow_interrupt_enable_q : transmit_clock_select_q,
                          falling_edge_enable_q, main_run_q, counter_timer_bit_q, capture_reload_select_q};
  always_comb begin
    unique case (sfr_addr)
      timer_two_pkg::ADDR_CTRL: rdata_d = ctrl_read;
      timer_two_pkg::ADDR_MODE: rdata_d = mode_q;
      timer_two_pkg::ADDR_MODE_EXT: rdata_d = ext_q;
      timer_two_pkg::ADDR_COUNT_LOW: rdata_d = tl_q;
      timer_two_pkg::ADDR_COUNT_HIGH: rdata_d = th_q;
      timer_two_pkg::ADDR_RELOAD_LOW: rdata_d = rcap_l_q;
      timer_two_pkg::ADDR_RELOAD_HIGH: rdata_d = rcap_h_q;
      default: rdata_d = timer_two_pkg::RESET_BYTE;
    endcase
  end

  // Prescaler, edges and datapath
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_q <= 4'h0;
      count_prev_q <= 1'b0;
      cap_prev_q <= 1'b0;
      tl_q <= timer_two_pkg::RESET_BYTE;
      th_q <= timer_two_pkg::RESET_BYTE;
      rcap_l_q <= timer_two_pkg::RESET_BYTE;
      rcap_h_q <= timer_two_pkg::RESET_BYTE;
    end else begin
      div_q <= div_d;
      count_prev_q <= pin_s[0];
      cap_prev_q <= cap_level;
      tl_q <= tl_d;
      th_q <= th_d;
      rcap_l_q <= rcap_l_d;
      rcap_h_q <= rcap_h_d;
    end
  end

  // Control registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode_q <= timer_two_pkg::RESET_BYTE;
      ext_q <= timer_two_pkg::RESET_BYTE;
      {overflow_flag_q, external_flag_q, low_overflow_flag_q} <= 3'h0;
      {receive_clock_select_q, transmit_clock_select_q, low_overflow_interrupt_enable_q} <= 3'h0;
      {falling_edge_enable_q, main_run_q, counter_timer_bit_q, capture_reload_select_q} <= 4'h0;
    end else begin
      overflow_flag_q <= overflow_flag_d;
      external_flag_q <= external_flag_d;
      low_overflow_flag_q <= low_overflow_flag_d;
      if (wr_mode) begin
        mode_q <= sfr_wdata;
      end
      mode_q[timer_two_pkg::MODE_LOW_RUN] <= low_run_d;
      if (wr_ext) begin
        ext_q <= sfr_wdata;
      end
      if (wr_ctrl) begin
        falling_edge_enable_q <= sfr_wdata[timer_two_pkg::CTRL_FALL_EN];
        main_run_q <= sfr_wdata[timer_two_pkg::CTRL_RUN];
        counter_timer_bit_q <= sfr_wdata[timer_two_pkg::CTRL_CT];
        capture_reload_select_q <= sfr_wdata[timer_two_pkg::CTRL_CPRL];
      end
      if (wr_ctrl && !bit_bank_select) begin
        receive_clock_select_q <= sfr_wdata[timer_two_pkg::CTRL_ALIAS_HI];
        transmit_clock_select_q <= sfr_wdata[timer_two_pkg::CTRL_ALIAS_LO];
      end
      if (wr_ctrl && bit_bank_select) begin
        low_overflow_interrupt_enable_q <= sfr_wdata[timer_two_pkg::CTRL_ALIAS_LO];
      end
    end
  end

  // Outputs, all registered
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      {clock_out_q, clock_out_oe_q, rx_q, tx_q, ovf_evt_q, irq_q} <= 6'h00;
      rdata_q <= timer_two_pkg::RESET_BYTE;
    end else begin
      clock_out_oe_q <= clock_output_enable;
      if (!clock_output_enable) begin
        clock_out_q <= 1'b0;
      end else if (t2_ovf && !capture_reload_select_q) begin
        clock_out_q <= ~clock_out_q;
      end
      rx_q <= receive_clock_select_q ? t2_ovf : timer_one_overflow;
      tx_q <= transmit_clock_select_q ? t2_ovf : timer_one_overflow;
      ovf_evt_q <= t2_ovf;
      irq_q <= (overflow_flag_q & ~overflow_interrupt_ignore) | external_flag_q
               | (low_overflow_flag_q & low_overflow_interrupt_enable_q);
      if (sfr_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign sfr_rdata = rdata_q;
  assign clock_out = clock_out_q;
  assign clock_out_oe = clock_out_oe_q;
  assign rx_baud_clock = rx_q;
  assign tx_baud_clock = tx_q;
  assign overflow_event = ovf_evt_q;
  assign timer_irq = irq_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  clock_toggle_a: assert property (t2_ovf && clock_output_enable && !capture_reload_select_q
                                   |=> clock_out_q != $past(clock_out_q))
    else $error("clock output did not toggle on overflow");
  full_reload_a: assert property (full_ovf && !capture_reload_select_q && !wr_tl && !wr_th
                                  |=> {th_q, tl_q} == $past({rcap_h_q, rcap_l_q}))
    else $error("count not reloaded on overflow");
  low_reload_a: assert property (low_byte_overflow_event && !wr_tl |=> tl_q == $past(rcap_l_q))
    else $error("low count not reloaded");
  overflow_set_a: assert property (hi_ovf && !serial_use |=> overflow_flag_q)
    else $error("overflow flag not set");
  serial_noflag_a: assert property (serial_use && !overflow_flag_q && !wr_ctrl |=> !overflow_flag_q)
    else $error("overflow flag set during serial use");
  flag_hold_a: assert property (external_flag_q && !wr_ctrl |=> external_flag_q)
    else $error("external flag cleared by hardware");
  ext_flag_a: assert property (ext_evt |=> external_flag_q)
    else $error("external flag not set on edge");
  serial_nocap_a: assert property (ext_evt && serial_use && !wr_rh && !wr_rl
                                   |=> $stable({rcap_h_q, rcap_l_q}))
    else $error("capture during serial use");
  irq_gate_a: assert property (overflow_flag_q && !overflow_interrupt_ignore ##1 overflow_flag_q
                               |-> timer_irq)
    else $error("interrupt missing for overflow");
  low_irq_a: assert property (low_overflow_flag_q && low_overflow_interrupt_enable_q |=> timer_irq)
    else $error("interrupt missing for low overflow");
  output_enable_a: assert property (##1 clock_out_oe == $past(clock_output_enable))
    else $error("output enable does not follow enable bit");
  run_clear_a: assert property (low_run_clear |=> !low_run)
    else $error("low run bit not cleared");
endmodule // timer_two_clock_out_control

// ==== dv/timer_pin_partner.sv ====
// Pin and serial side of the timer: pulled-up output pin, edge and pulse counts.
// Assumes the timer outputs are registered on sys_clk.
`timescale 1ns/1ps
module timer_pin_partner (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Timer outputs
  input wire logic clock_out,
  input wire logic clock_out_oe,
  input wire logic rx_baud_clock,
  // Pin level and counts
  output logic pin_level,
  output int toggles,
  output int rx_pulses
);
  logic last_q;
  // Released pin floats to the pull-up, not the last level
  assign pin_level = clock_out_oe ? clock_out : 1'b1;
  always @(posedge sys_clk) begin
    last_q <= pin_level;
    if (sys_rst) begin
      toggles <= 0;
      rx_pulses <= 0;
    end else begin
      if (pin_level !== last_q) toggles <= toggles + 1;
      if (rx_baud_clock) rx_pulses <= rx_pulses + 1;
    end
  end
endmodule // timer_pin_partner

// ==== dv/timer_two_clock_out_control_tb.sv ====
// Self-checking bench: registers, clock-out, serial routing, split mode, edges.
// Assumes the partner model stands for the pin and serial port.
`timescale 1ns/1ps
module timer_two_clock_out_control_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic trig = 1'b1;
  logic [9:0] noise = 10'h000;
  logic route_on = 1'b0;
  logic [7:0] sfr_rdata, r;
  logic clock_out, clock_out_oe, rx_baud_clock, tx_baud_clock, timer_irq, pin_level, rd_q, t1_q;
  logic ovf_ev;
  int toggles, rx_pulses, n0, r0, o0;
  int ovf_n = 0;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [7:0] exp_q[$];
  logic [7:0] addrs[8] = '{8'h93, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h00};

  initial forever #25 sys_clk = ~sys_clk;

  timer_two_clock_out_control dut_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .count_pin(noise[0]), .external_trigger_input(trig), .serial_receive_input(noise[1]),
    .port6_bit0(noise[2]), .two_wire_clock_line(noise[3]),
    .external_interrupt0_event(noise[4]), .external_interrupt2_event(noise[5]),
    .baud_generator_overflow(noise[6]), .timer_zero_overflow(noise[7]),
    .timer_one_overflow(noise[8]), .keypad_event(noise[9]),
    .clock_out(clock_out), .clock_out_oe(clock_out_oe), .rx_baud_clock(rx_baud_clock),
    .tx_baud_clock(tx_baud_clock), .overflow_event(ovf_ev), .timer_irq(timer_irq)
  );

  timer_pin_partner pin_u (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clock_out(clock_out), .clock_out_oe(clock_out_oe),
    .rx_baud_clock(rx_baud_clock), .pin_level(pin_level), .toggles(toggles), .rx_pulses(rx_pulses)
  );

  // Unselected sources keep toggling so a wrong select shows up
  always @(posedge sys_clk) noise <= 10'($urandom);
  always @(posedge sys_clk) t1_q <= noise[8];
  always @(posedge sys_clk) rd_q <= sfr_rd;
  always @(posedge sys_clk) if (ovf_ev) ovf_n <= ovf_n + 1;
  always @(negedge sys_clk) if (route_on) check(16'(tx_baud_clock), 16'(t1_q));
  always @(negedge sys_clk) if (rd_q) check(16'(sfr_rdata), 16'(exp_q.pop_front()));

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    exp_q.push_back(d);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
  endtask

  // Waits for one toggle, then counts the following half period
  task automatic half(input logic [15:0] want);
    int n;
    logic v;
    repeat (2) begin
      v = clock_out;
      n = 0;
      while (clock_out === v && n < 2000) begin
        @(negedge sys_clk);
        n++;
      end
    end
    check(16'(n), want);
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    void'($urandom(41));
    wait_n(6);
    sys_rst <= 1'b0;
    wait_n(2);
    route_on <= 1'b1;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    r = 8'($urandom);
    wr(8'hca, r);
    rd(8'hca, r);
    wr(8'h93, r);
    rd(8'h93, r);
    wr(8'h00, r);
    rd(8'h00, 8'h00);
    wr(8'h93, 8'h00);
    // Clock-out in programming order, reload 0xfff0 on the system clock
    wr(8'hc9, 8'h10);
    @(negedge sys_clk);
    check(16'({clock_out_oe, pin_level}), 16'h1);
    wr(8'hca, 8'hf0);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hf0);
    wr(8'hcd, 8'hff);
    wr(8'hc9, 8'h12);
    wr(8'hc8, 8'h04);
    half(16'd16);
    half(16'd16);
    check(16'({clock_out_oe, pin_level === clock_out}), 16'h3);
    // Stop but keep the flag, then gate its interrupt
    wr(8'hc8, 8'h80);
    wait_n(3);
    @(negedge sys_clk);
    check(16'(timer_irq), 16'h1);
    wr(8'h93, 8'h40);
    wait_n(3);
    @(negedge sys_clk);
    check(16'(timer_irq), 16'h0);
    rd(8'hc8, 8'h80);
    wr(8'h93, 8'h00);
    wr(8'hc8, 8'h00);
    rd(8'hc8, 8'h00);
    // Same overflow stream to receive clock and pin
    // Select first: until then the receive clock still carries timer one
    wr(8'hc8, 8'h20);
    wait_n(3);
    n0 = toggles;
    r0 = rx_pulses;
    o0 = ovf_n;
    wr(8'hc8, 8'h24);
    wait_n(100);
    wr(8'hc8, 8'h20);
    wait_n(4);
    check(16'(toggles - n0), 16'(rx_pulses - r0));
    check(16'(ovf_n - o0), 16'(rx_pulses - r0));
    check(16'(rx_pulses - r0 > 3), 16'h1);
    rd(8'hc8, 8'h20);
    wr(8'hc8, 8'h00);
    // Split: low counter alone, reload 0xf8
    wr(8'h93, 8'h20);
    wr(8'hc9, 8'h40);
    wr(8'hca, 8'hf8);
    wr(8'hcc, 8'hf8);
    wr(8'hc9, 8'hca);
    half(16'd8);
    wait_n(2);
    @(negedge sys_clk);
    check(16'(timer_irq), 16'h0);
    wr(8'hc8, 8'h30);
    wait_n(3);
    @(negedge sys_clk);
    check(16'(timer_irq), 16'h1);
    rd(8'hc8, 8'h30);
    wr(8'hc9, 8'h00);
    wr(8'hc8, 8'h00);
    rd(8'hc8, 8'h00);
    wr(8'h93, 8'h00);
    // Trigger edges: reload normally, flag only under serial use
    wr(8'hc9, 8'h01);
    wr(8'hca, 8'h34);
    wr(8'hcc, 8'h12);
    wr(8'hc8, 8'h08);
    trig <= 1'b0;
    wait_n(8);
    rd(8'hc8, 8'h48);
    rd(8'hcc, 8'h34);
    wr(8'hcc, 8'h12);
    wr(8'hc8, 8'h28);
    trig <= 1'b1;
    wait_n(8);
    rd(8'hc8, 8'h28);
    trig <= 1'b0;
    wait_n(8);
    rd(8'hc8, 8'h68);
    rd(8'hcc, 8'h12);
    // Capture with auto-zero: count into reload low, count cleared
    wr(8'hc8, 8'h09);
    wr(8'hcc, 8'h56);
    trig <= 1'b1;
    wait_n(8);
    trig <= 1'b0;
    wait_n(8);
    rd(8'hca, 8'h56);
    rd(8'hcc, 8'h00);
    rd(8'hc8, 8'h49);
    wait_n(3);
    wrap_up();
  end
endmodule // timer_two_clock_out_control_tb
